// ==== hdl/abo_pkg.sv ====
/*
  abo_pkg: constants, op codes and carrier types of the accumulator bit-operation unit.
  assumes one 100 MHz clock and a register port on AHB-Lite, low 8 address bits decoded.
*/
// How it works
// - popcount writes the number of one bits into the accumulator
// - popcount, shifts, rotates and BCD convert set zero flag when result is zero
// - shifts, rotates and BCD convert set negative flag from result bit 31
// - shift left by count, zeros enter at bottom, top bits dropped
// - shift right by count, zeros enter at top, bottom bits dropped
// - rotate left by count, bits wrap from top to bottom
// - rotate right by count, bits wrap from bottom to top
// - encode writes index of set bit, top bit gives 1F hex
// - encode of zero or of only bit zero writes zero
// - encode with several bits set returns lowest index and sets range flag
// - decode sets the accumulator bit selected by a 5-bit index
// - decode index above 31 is divided by 32 until below 32
// - BCD convert turns packed decimal digits into a binary value
// - BCD convert sets invalid-number flag on any nibble above nine
// - a flag holds until the next operation that updates that flag
package abo_pkg;

  localparam int ABO_ACC_W = 32;
  localparam int ABO_CNT_W = 6;
  localparam int ABO_DEC_IDX_W = 5;
  localparam int ABO_BCD_DIGITS = 8;
  localparam int ABO_NIB_W = 4;
  localparam int ABO_ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] ABO_OFF_ACC = 8'h00;
  localparam logic [7:0] ABO_OFF_CMD = 8'h04;
  localparam logic [7:0] ABO_OFF_COUNT = 8'h08;
  localparam logic [7:0] ABO_OFF_FLAGS = 8'h0C;
  localparam logic [7:0] ABO_OFF_INT_STATUS = 8'h10;
  localparam logic [7:0] ABO_OFF_INT_MASK = 8'h14;

  // field positions
  localparam int ABO_BUSY_BIT = 8;
  localparam int ABO_FLAGS_W = 4;
  localparam int ABO_IRQ_W = 4;

  localparam logic [5:0] ABO_ROT_SPAN = 6'h20;
  localparam logic [3:0] ABO_BCD_MAX_DIGIT = 4'h9;
  localparam logic [31:0] ABO_BCD_RADIX = 32'h0000000A;
  localparam logic [31:0] ABO_ONE = 32'h00000001;
  localparam logic [1:0] ABO_HRESP_OKAY = 2'h0;

  typedef enum logic [3:0] {
    ABO_OP_NONE = 4'h0,
    ABO_OP_POPCOUNT = 4'h1,
    ABO_OP_SHIFT_LEFT = 4'h2,
    ABO_OP_SHIFT_RIGHT = 4'h3,
    ABO_OP_ROTATE_LEFT = 4'h4,
    ABO_OP_ROTATE_RIGHT = 4'h5,
    ABO_OP_ENCODE = 4'h6,
    ABO_OP_DECODE = 4'h7,
    ABO_OP_BCD_TO_BINARY = 4'h8
  } abo_op_type;

  typedef enum logic [0:0] {
    ABO_IDLE = 1'b0,
    ABO_REDUCE = 1'b1
  } abo_fsm_type;

  // status flags, bit 0 upward: zero, negative, range, invalid
  typedef struct packed {
    logic invalid_number_flag;
    logic operand_range_flag;
    logic negative_flag;
    logic zero_flag;
  } abo_flags_type;

  // interrupt events, bit 0 upward: done, range, invalid, refused
  typedef struct packed {
    logic refused;
    logic invalid;
    logic range;
    logic done;
  } abo_irq_type;

  typedef struct packed {
    abo_fsm_type fsm;
    logic [ABO_ACC_W-1:0] acc;
    logic [ABO_CNT_W-1:0] count;
    abo_flags_type flags;
    abo_irq_type int_status;
    abo_irq_type int_mask;
    logic wr_pend;
    logic [ABO_ADDR_W-1:0] wr_addr;
    logic [ABO_ACC_W-1:0] rdata;
  } abo_state_type;

  localparam abo_state_type ABO_STATE_RST = '0;

endpackage : abo_pkg

// ==== hdl/abo_unit.sv ====
/*
  abo_unit: accumulator bit-operation unit with its AHB-Lite register slave.
  assumes a single-slave AHB-Lite bus, word transfers only, one clock hclk.
*/
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module abo_unit (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // status
  output logic zero_flag,
  output logic negative_flag,
  output logic operand_range_flag,
  output logic invalid_number_flag,
  output logic busy,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] abo_popcount(
    input logic [31:0] a
  );
    logic [31:0] n;
    n = '0;
    for (int i = 0; i < abo_pkg::ABO_ACC_W; i++) begin
      n = n + 32'(a[i]);
    end
    return n;
  endfunction : abo_popcount

  // descending scan so the lowest set bit wins
  function automatic logic [31:0] abo_encode(
    input logic [31:0] a
  );
    logic [4:0] idx;
    idx = '0;
    for (int i = abo_pkg::ABO_ACC_W - 1; i >= 0; i--) begin
      if (a[i]) begin
        idx = 5'(i);
      end
    end
    return 32'(idx);
  endfunction : abo_encode

  // invalid nibbles are weighted as they stand
  function automatic logic [31:0] abo_bcd_value(
    input logic [31:0] a
  );
    logic [31:0] r;
    r = '0;
    for (int i = abo_pkg::ABO_BCD_DIGITS - 1; i >= 0; i--) begin
      r = 32'(r * abo_pkg::ABO_BCD_RADIX) + 32'(a[i*abo_pkg::ABO_NIB_W +: abo_pkg::ABO_NIB_W]);
    end
    return r;
  endfunction : abo_bcd_value

  function automatic logic abo_bcd_bad(
    input logic [31:0] a
  );
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < abo_pkg::ABO_BCD_DIGITS; i++) begin
      if (a[i*abo_pkg::ABO_NIB_W +: abo_pkg::ABO_NIB_W] > abo_pkg::ABO_BCD_MAX_DIGIT) begin
        bad = 1'b1;
      end
    end
    return bad;
  endfunction : abo_bcd_bad

  function automatic logic [31:0] abo_rotate_left_op(
    input logic [31:0] a,
    input logic [4:0] r
  );
    return (a << r) | (a >> (abo_pkg::ABO_ROT_SPAN - {1'b0, r}));
  endfunction : abo_rotate_left_op

  function automatic logic [31:0] abo_rotate_right_op(
    input logic [31:0] a,
    input logic [4:0] r
  );
    return (a >> r) | (a << (abo_pkg::ABO_ROT_SPAN - {1'b0, r}));
  endfunction : abo_rotate_right_op

  ////////////////////////////////////////////////////////////
  // state

  abo_pkg::abo_state_type s_r;
  abo_pkg::abo_state_type s_nxt;

  ////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    abo_pkg::abo_irq_type ev;
    logic [31:0] res;
    logic [31:0] rd;
    logic is_busy;
    logic addr_ok;
    abo_pkg::abo_op_type op;
    ev = '0;
    res = '0;
    rd = '0;
    op = abo_pkg::ABO_OP_NONE;
    s_nxt = s_r;
    is_busy = (s_r.fsm != abo_pkg::ABO_IDLE);
    addr_ok = hsel & hready & htrans[1];

    // decode reduction, one divide by 32 per cycle
    case (s_r.fsm)
      abo_pkg::ABO_IDLE: begin
      end
      abo_pkg::ABO_REDUCE: begin
        if (|s_r.acc[abo_pkg::ABO_ACC_W-1:abo_pkg::ABO_DEC_IDX_W]) begin
          s_nxt.acc = s_r.acc >> abo_pkg::ABO_DEC_IDX_W;
        end else begin
          s_nxt.acc = abo_pkg::ABO_ONE << s_r.acc[abo_pkg::ABO_DEC_IDX_W-1:0];
          s_nxt.fsm = abo_pkg::ABO_IDLE;
          ev.done = 1'b1;
        end
      end
      default: begin
        s_nxt.fsm = abo_pkg::ABO_IDLE;
      end
    endcase

    // write data phase
    if (s_r.wr_pend) begin
      case (s_r.wr_addr)
        abo_pkg::ABO_OFF_ACC: begin
          if (is_busy) begin
            ev.refused = 1'b1;
          end else begin
            s_nxt.acc = hwdata;
          end
        end
        abo_pkg::ABO_OFF_COUNT: begin
          s_nxt.count = hwdata[abo_pkg::ABO_CNT_W-1:0];
        end
        abo_pkg::ABO_OFF_INT_STATUS: begin
          s_nxt.int_status = s_r.int_status & ~abo_pkg::abo_irq_type'(hwdata[abo_pkg::ABO_IRQ_W-1:0]);
        end
        abo_pkg::ABO_OFF_INT_MASK: begin
          s_nxt.int_mask = abo_pkg::abo_irq_type'(hwdata[abo_pkg::ABO_IRQ_W-1:0]);
        end
        abo_pkg::ABO_OFF_CMD: begin
          op = abo_pkg::abo_op_type'(hwdata[3:0]);
          if (is_busy) begin
            ev.refused = 1'b1;
            op = abo_pkg::ABO_OP_NONE;
          end
        end
        default: begin
        end
      endcase
    end

    // operation, result lands at the end of the command data phase, except a decode of an index above 31, which ends in ABO_REDUCE
    // flags not touched by an op are left alone
    case (op)
      abo_pkg::ABO_OP_NONE: begin
      end
      abo_pkg::ABO_OP_POPCOUNT: begin
        res = abo_popcount(s_r.acc);
        s_nxt.acc = res;
        s_nxt.flags.zero_flag = (res == '0);
        ev.done = 1'b1;
      end
      abo_pkg::ABO_OP_SHIFT_LEFT,
      abo_pkg::ABO_OP_SHIFT_RIGHT,
      abo_pkg::ABO_OP_ROTATE_LEFT,
      abo_pkg::ABO_OP_ROTATE_RIGHT: begin
        if (op == abo_pkg::ABO_OP_SHIFT_LEFT) begin
          res = s_r.acc << s_r.count;
        end else if (op == abo_pkg::ABO_OP_SHIFT_RIGHT) begin
          res = s_r.acc >> s_r.count;
        end else if (op == abo_pkg::ABO_OP_ROTATE_LEFT) begin
          res = abo_rotate_left_op(s_r.acc, s_r.count[abo_pkg::ABO_DEC_IDX_W-1:0]);
        end else begin
          res = abo_rotate_right_op(s_r.acc, s_r.count[abo_pkg::ABO_DEC_IDX_W-1:0]);
        end
        s_nxt.acc = res;
        s_nxt.flags.zero_flag = (res == '0);
        s_nxt.flags.negative_flag = res[abo_pkg::ABO_ACC_W-1];
        ev.done = 1'b1;
      end
      abo_pkg::ABO_OP_ENCODE: begin
        s_nxt.acc = abo_encode(s_r.acc);
        s_nxt.flags.operand_range_flag = (abo_popcount(s_r.acc) > abo_pkg::ABO_ONE);
        ev.range = s_nxt.flags.operand_range_flag;
        ev.done = 1'b1;
      end
      abo_pkg::ABO_OP_DECODE: begin
        if (|s_r.acc[abo_pkg::ABO_ACC_W-1:abo_pkg::ABO_DEC_IDX_W]) begin
          s_nxt.acc = s_r.acc >> abo_pkg::ABO_DEC_IDX_W;
          s_nxt.fsm = abo_pkg::ABO_REDUCE;
        end else begin
          s_nxt.acc = abo_pkg::ABO_ONE << s_r.acc[abo_pkg::ABO_DEC_IDX_W-1:0];
          ev.done = 1'b1;
        end
      end
      abo_pkg::ABO_OP_BCD_TO_BINARY: begin
        res = abo_bcd_value(s_r.acc);
        s_nxt.acc = res;
        s_nxt.flags.zero_flag = (res == '0);
        s_nxt.flags.negative_flag = res[abo_pkg::ABO_ACC_W-1];
        s_nxt.flags.invalid_number_flag = abo_bcd_bad(s_r.acc);
        ev.invalid = s_nxt.flags.invalid_number_flag;
        ev.done = 1'b1;
      end
      default: begin
        ev.refused = 1'b1;
      end
    endcase

    // a new event beats a same-cycle clear
    s_nxt.int_status = s_nxt.int_status | ev;

    // address phase; read data taken from the updated state
    s_nxt.wr_pend = addr_ok & hwrite;
    s_nxt.wr_addr = haddr[abo_pkg::ABO_ADDR_W-1:0];
    if (addr_ok && !hwrite) begin
      case (haddr[abo_pkg::ABO_ADDR_W-1:0])
        abo_pkg::ABO_OFF_ACC: begin
          rd = s_nxt.acc;
        end
        abo_pkg::ABO_OFF_COUNT: begin
          rd = 32'(s_nxt.count);
        end
        abo_pkg::ABO_OFF_FLAGS: begin
          rd = 32'(s_nxt.flags);
          rd[abo_pkg::ABO_BUSY_BIT] = (s_nxt.fsm != abo_pkg::ABO_IDLE);
        end
        abo_pkg::ABO_OFF_INT_STATUS: begin
          rd = 32'(s_nxt.int_status);
        end
        abo_pkg::ABO_OFF_INT_MASK: begin
          rd = 32'(s_nxt.int_mask);
        end
        default: begin
          rd = '0;
        end
      endcase
      s_nxt.rdata = rd;
    end
  end

  ////////////////////////////////////////////////////////////
  // register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= abo_pkg::ABO_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  // outputs

  assign hreadyout = 1'b1;
  assign hresp = abo_pkg::ABO_HRESP_OKAY[0];
  assign hrdata = s_r.rdata;
  assign zero_flag = s_r.flags.zero_flag;
  assign negative_flag = s_r.flags.negative_flag;
  assign operand_range_flag = s_r.flags.operand_range_flag;
  assign invalid_number_flag = s_r.flags.invalid_number_flag;
  assign busy = (s_r.fsm != abo_pkg::ABO_IDLE);
  assign irq = |(s_r.int_status & s_r.int_mask);

endmodule : abo_unit

`default_nettype wire

// ==== test/abo_checker.sv ====
/* abo_checker: port assertions of abo_unit.
   assumes the bind at the foot and one clock hclk. */
`timescale 1ns/1ps
`default_nettype none
module abo_checker (
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  // status
  input wire logic zero_flag,
  input wire logic negative_flag,
  input wire logic operand_range_flag,
  input wire logic invalid_number_flag,
  input wire logic busy
);
  logic cmd_r;
  logic [3:0] op;
  logic [3:0] fl;
  assign op = hwdata[3:0];
  assign fl = {invalid_number_flag, operand_range_flag, negative_flag, zero_flag};
  // high in the data phase of a command write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cmd_r <= 1'b0;
    else cmd_r <= hsel && htrans[1] && hwrite && haddr[7:0] == abo_pkg::ABO_OFF_CMD;
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////
  a_flags_hold: assert property (!cmd_r |=> $stable(fl)) else $error("flags moved");
  a_enc_keeps: assert property (cmd_r && op == 4'h6 |=> $stable({fl[3], fl[1:0]})) else $error("encode");
  a_pop_keeps: assert property (cmd_r && op == 4'h1 |=> $stable(fl[3:1])) else $error("popcount");
  a_shift_keeps: assert property (cmd_r && op inside {[4'h2:4'h5]} |=> $stable(fl[3:2])) else $error("shift");
  a_dec_keeps: assert property (cmd_r && op == 4'h7 |=> $stable(fl)) else $error("decode");
  a_zn_excl: assert property (
    cmd_r && op inside {[4'h2:4'h5], 4'h8} && !busy |=> !(zero_flag && negative_flag))
    else $error("zero and negative");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:6] !busy) else $error("busy too long");
  a_busy_cause: assert property ($rose(busy) |-> $past(cmd_r) && $past(op) == 4'h7) else $error("busy cause");
  cover property (cmd_r && op == 4'h6 ##1 operand_range_flag);
  cover property ($fell(busy));
  cover property (cmd_r && op == 4'h8 ##1 invalid_number_flag);
endmodule : abo_checker
bind abo_unit abo_checker abo_checker_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .zero_flag(zero_flag), .negative_flag(negative_flag),
  .operand_range_flag(operand_range_flag), .invalid_number_flag(invalid_number_flag), .busy(busy));
`default_nettype wire

// ==== test/abo_master.sv ====
/* abo_master: AHB-Lite master in the place of the instruction sequencer.
   assumes one slave whose hreadyout comes back as hready. */
`timescale 1ns/1ps
`default_nettype none
module abo_master (
  // clock
  input wire logic hclk,
  // ahb-lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one word transfer, entered right after a rising edge
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    // released data never repeats the last word
    hwdata <= ~d;
  endtask : xfer
endmodule : abo_master
`default_nettype wire

// ==== test/tb_top.sv ====
/* tb_top: self-checking bench of abo_unit.
   assumes abo_pkg, abo_master and abo_checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  wire hsel, hwrite, hready, rsp, busy, irq, zf, nf, rf, vf;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] haddr, hwdata, hrdata;
  logic [31:0] q, a, e;
  logic [5:0] c;
  logic [3:0] op, fl;
  logic [43:0] corner [11];
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int i;
  abo_master abo_master_inst (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
  abo_unit abo_unit_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
    .hresp(rsp), .zero_flag(zf), .negative_flag(nf), .operand_range_flag(rf), .invalid_number_flag(vf),
    .busy(busy), .irq(irq));
  initial begin
    forever #5 hclk = ~hclk;
  end
  //////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    abo_master_inst.xfer(1'b1, ad, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    abo_master_inst.xfer(1'b0, ad, 32'h0, q);
  endtask : rd
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      @(negedge hclk);
      k++;
    end while (busy !== 1'b0 && k < 9);
    @(posedge hclk);
  endtask : wait_idle
  task automatic irq_is(input logic x);
    @(negedge hclk);
    chk("irq", irq, x);
    @(posedge hclk);
  endtask : irq_is
  function automatic logic [31:0] f_res(input logic [3:0] o, input logic [31:0] v, input logic [5:0] n);
    logic [31:0] r, t;
    r = 32'h0;
    t = v;
    case (o)
      4'h1: r = $countones(v);
      4'h2: r = v << n;
      4'h3: r = v >> n;
      4'h4: begin
        r = v;
        repeat (n) r = {r[30:0], r[31]};
      end
      4'h5: begin
        r = v;
        repeat (n) r = {r[0], r[31:1]};
      end
      4'h6: for (int j = 31; j >= 0; j--) if (v[j]) r = j;
      4'h7: begin
        while (t > 32'h1F) t = t / 32'h20;
        r = 32'h1 << t[4:0];
      end
      4'h8: for (int j = 7; j >= 0; j--) r = r * 32'hA + v[4*j+:4];
      default: r = v;
    endcase
    return r;
  endfunction : f_res
  task automatic run(input logic [3:0] o, input logic [31:0] v, input logic [5:0] n);
    wr(abo_pkg::ABO_OFF_ACC, v);
    wr(abo_pkg::ABO_OFF_COUNT, {26'h0, n});
    wr(abo_pkg::ABO_OFF_CMD, {28'h0, o});
    wait_idle();
    e = f_res(o, v, n);
    if (o inside {[4'h1:4'h5], 4'h8}) fl[0] = e == 32'h0;
    if (o inside {[4'h2:4'h5], 4'h8}) fl[1] = e[31];
    if (o == 4'h6) fl[2] = $countones(v) > 1;
    if (o == 4'h8) fl[3] = 1'b0;
    for (int j = 0; j < 8; j++) if (o == 4'h8 && v[4*j+:4] > 4'h9) fl[3] = 1'b1;
    rd(abo_pkg::ABO_OFF_ACC);
    chk("acc", q, e);
    chk("flags", {vf, rf, nf, zf}, fl);
    rd(abo_pkg::ABO_OFF_FLAGS);
    chk("flags reg", q, {28'h0, fl});
    rd(abo_pkg::ABO_OFF_COUNT);
    chk("count", q, {26'h0, n});
  endtask : run
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(23086));
    corner = '{44'h60080000000, 44'h60000000001, 44'h60000000000, 44'h60000000014, 44'h7000000000F,
      44'h700000003E8, 44'h80012345678, 44'h8000000001A, 44'h22000000001, 44'h52080000001, 44'h10000000000};
    fl = 4'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(abo_pkg::ABO_OFF_ACC);
    chk("acc after reset", q, 32'h0);
    chk("hresp", rsp, 1'b0);
    chk("hready", hready, 1'b1);
    rd(8'h18);
    chk("unmapped", q, 32'h0);
    for (i = 0; i < 80; i++) begin
      op = (i < 11) ? corner[i][43:40] : 4'($urandom_range(8, 1));
      c = (i < 11) ? corner[i][37:32] : 6'($urandom_range(32, 1));
      a = (i < 11) ? corner[i][31:0] : $urandom;
      run(op, a, c);
    end
    // an accumulator write during a long decode is refused
    wr(abo_pkg::ABO_OFF_INT_STATUS, 32'h0000000F);
    wr(abo_pkg::ABO_OFF_ACC, 32'hFFFFFFFF);
    wr(abo_pkg::ABO_OFF_CMD, 32'h00000007);
    wr(abo_pkg::ABO_OFF_ACC, 32'h00000000);
    rd(abo_pkg::ABO_OFF_FLAGS);
    chk("busy bit", q[8], 1'b1);
    @(negedge hclk);
    chk("busy pin", busy, 1'b1);
    wait_idle();
    rd(abo_pkg::ABO_OFF_ACC);
    chk("acc busy", q, f_res(4'h7, 32'hFFFFFFFF, 6'h0));
    rd(abo_pkg::ABO_OFF_INT_STATUS);
    chk("refused", q[3], 1'b1);
    chk("flags kept", {vf, rf, nf, zf}, fl);
    wr(abo_pkg::ABO_OFF_INT_STATUS, 32'h0000000F);
    wr(abo_pkg::ABO_OFF_CMD, 32'h0000000F);
    rd(abo_pkg::ABO_OFF_INT_STATUS);
    chk("bad op", q, 32'h00000008);
    chk("flags after bad op", {vf, rf, nf, zf}, fl);
    wr(abo_pkg::ABO_OFF_INT_STATUS, 32'h0000000F);
    wr(abo_pkg::ABO_OFF_INT_MASK, 32'h00000000);
    wr(abo_pkg::ABO_OFF_CMD, 32'h00000001);
    irq_is(1'b0);
    wr(abo_pkg::ABO_OFF_INT_MASK, 32'h00000001);
    irq_is(1'b1);
    rd(abo_pkg::ABO_OFF_INT_MASK);
    chk("mask", q, 32'h00000001);
    wr(abo_pkg::ABO_OFF_INT_STATUS, 32'h00000001);
    irq_is(1'b0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
